// *** hdl/front_panel_pkg.sv ***
`default_nettype none
package front_panel_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned FAST_CLK_PERIOD_NS = 100;
  localparam int unsigned FAST_DIV_CYCLES =
    FAST_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_TIME_US = 1000;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned DBNC_CNT_W = 20;
  localparam logic [3:0] BURST_PULSES = 4'h8;
  localparam logic [3:0] SINGLE_PULSE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and pushbutton positions.
  localparam int unsigned NUM_READOUTS = 12;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned NUM_BTN = 15;
  localparam int unsigned NUM_DIGIT_KEYS = 8;
  localparam int unsigned BTN_ADDR = 8;
  localparam int unsigned BTN_DATA = 9;
  localparam int unsigned BTN_CLEAR = 10;
  localparam int unsigned BTN_RUN = 11;
  localparam int unsigned BTN_HALT = 12;
  localparam int unsigned BTN_ADVANCE = 13;
  localparam int unsigned BTN_RESET = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets and field positions.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_KEYPAD = 8'h0c;
  localparam logic [7:0] REG_TAPE = 8'h10;
  localparam int unsigned CTRL_ONE_SHOT = 0;
  localparam int unsigned CTRL_BYTE_STEP = 1;
  localparam int unsigned CTRL_FLAGS_LSB = 4;
  localparam int unsigned CMD_RUN = 0;
  localparam int unsigned CMD_HALT = 1;
  localparam int unsigned STAT_ERR_LSB = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Display masks, readout one at the most significant bit.
  localparam logic [11:0] BLANK_HOST = 12'h0c0;
  localparam logic [11:0] BLANK_KEYBD = 12'h1c0;
  localparam logic [11:0] BLANK_KEY_DIGITS = 12'he00;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {CLK_SW_CENTER, CLK_SW_NORMAL, CLK_SW_ONE_SHOT}
    clk_sw_t;
  typedef enum logic [1:0] {SW3_CENTER, SW3_ON, SW3_OFF} sw3_t;
  typedef enum logic [2:0] {DISP_LAMP, DISP_STATUS, DISP_ACCUM, DISP_HOST,
    DISP_KEYBD} disp_pos_t;
  typedef enum logic [1:0] {GATE_FREE, GATE_IDLE, GATE_BURST} gate_t;

  typedef struct packed {
    logic test_panel;
    logic load;
    logic keyboard_src;
    clk_sw_t clk_sw;
    sw3_t byte_sw;
    disp_pos_t disp_pos;
  } panel_sw_t;

  typedef struct packed {
    logic pre_write_buffer_flag;
    logic chain;
    logic remote_processor_format;
    logic write;
  } flags_t;

  typedef struct packed {
    logic lamp_test;
    logic blank;
    logic dp;
    logic [2:0] value;
  } readout_t;

  typedef struct packed {
    logic [NUM_BTN-1:0] sync1;
    logic [NUM_BTN-1:0] sync2;
    logic [NUM_BTN-1:0] stable;
    logic [NUM_BTN-1:0][DBNC_CNT_W-1:0] dbnc_cnt;
    logic [NUM_BTN-1:0] press;
    logic [8:0] interim;
    logic [7:0] mar;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0] tape_reg;
    logic run_halt_flag;
    logic halt_pend;
    flags_t flags;
    logic prog_one_shot;
    logic prog_byte_step;
    logic tape_stop;
    logic tape_perr;
    logic [3:0] status_err;
    gate_t gate;
    logic [3:0] div;
    logic [3:0] byte_sel;
    logic tick;
    logic [31:0] rdata;
    readout_t [NUM_READOUTS-1:0] disp;
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam flags_t FLAGS_RESET = '{pre_write_buffer_flag: 1'b1,
    chain: 1'b1, remote_processor_format: 1'b0, write: 1'b0};
  localparam state_t ST_RESET = '{flags: FLAGS_RESET, gate: GATE_FREE,
    default: '0};

endpackage
`default_nettype wire

// *** hdl/front_panel_control.sv ***
// How it works
// - Test panel mode disables host run, halt and control writes.
// - Non-center panel switch beats host command.
// - Load mode opens memory; operate runs normally.
// - Keyboard/reader choice matters only in load.
// - Digits shift into three-digit interim register.
// - Address key copies interim, keeps it.
// - Data key writes byte, then increments address.
// - Clear key zeroes the interim register.
// - Interim kept; repeated data key repeats byte.
// - Reset clears registers, counter, flags; halts. Flags load 4'hc instead, and the reset button keeps the address.
// - Run starts in previously configured mode.
// - Halt waits for instruction end.
// - Position two shows status, four octal bytes.
// - Position three: accumulator, parity on point.
// - Position four: host address, blanks, memory.
// - Position five: keyboard, blanks, memory.
// - Keyboard digits blank unless load keyboard.
// - Entered digits show at once.
// - Normal runs 10 MHz; one-shot one pulse.
// - Off-center clock switch overrides software.
// - Byte step gives eight pulses per advance.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module front_panel_control
  import front_panel_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Panel switches and pushbuttons.
  input wire panel_sw_t panel_sw,
  input wire logic [NUM_BTN-1:0] buttons,
  // Host input/output interface commands.
  input wire logic host_run_req,
  input wire logic host_halt_req,
  // Core and tape reader.
  input wire logic instr_done,
  input wire logic tape_valid,
  input wire logic [7:0] tape_byte,
  input wire logic tape_parity_bad,
  input wire logic [3:0] err_evt,
  // Display sources.
  input wire logic [31:0] status_word,
  input wire logic [31:0] accum_word,
  input wire logic [11:0] host_addr,
  // Outputs.
  output readout_t [NUM_READOUTS-1:0] readouts,
  output logic timing_tick,
  output logic run_lamp,
  output flags_t mode_flags,
  output logic tape_stop,
  output logic tape_parity_err,
  output logic [3:0] status_err
);

  ////////////////////////////////////////////////////////////////////////////
  // Derived constants.
  localparam logic [DBNC_CNT_W-1:0] DBNC_LAST =
    DBNC_CNT_W'(DEBOUNCE_LEN - 1);
  localparam logic [3:0] FAST_DIV_LAST = 4'(FAST_DIV_CYCLES - 1);

  state_t st_ff;
  state_t nxt_st;
  logic host_en;
  logic kbd_mode;
  logic reader_mode;
  logic one_shot_eff;
  logic byte_eff;
  logic tick10;
  logic run_cmd;
  logic halt_cmd;
  logic [35:0] dsrc;
  logic [11:0] dblank;
  logic [11:0] ddp;
  logic dlamp;
  wire readout_t [NUM_READOUTS-1:0] disp_next;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode shared by the whole block.
  assign host_en = ~panel_sw.test_panel;
  assign kbd_mode = panel_sw.load & panel_sw.keyboard_src;
  assign reader_mode = panel_sw.load & ~panel_sw.keyboard_src;
  // A forced normal clock also locks out byte stepping.
  assign one_shot_eff = (panel_sw.clk_sw == CLK_SW_ONE_SHOT) |
    ((panel_sw.clk_sw == CLK_SW_CENTER) & st_ff.prog_one_shot);
  assign byte_eff = (panel_sw.clk_sw != CLK_SW_NORMAL) &
    ((panel_sw.byte_sw == SW3_ON) |
    ((panel_sw.byte_sw == SW3_CENTER) & st_ff.prog_byte_step));
  assign tick10 = (st_ff.div == FAST_DIV_LAST);

  // Panel buttons always act; host and bus commands only in host mode.
  assign run_cmd = st_ff.press[BTN_RUN] | (host_en & (host_run_req |
    (reg_wr & (reg_addr == REG_CMD) & reg_wdata[CMD_RUN])));
  assign halt_cmd = st_ff.press[BTN_HALT] | (host_en & (host_halt_req |
    (reg_wr & (reg_addr == REG_CMD) & reg_wdata[CMD_HALT])));

  ////////////////////////////////////////////////////////////////////////////
  // Display source selection, readout one at the top bits.
  always_comb
  begin
    dsrc = '0;
    dblank = '0;
    ddp = '0;
    dlamp = 1'b0;
    case (panel_sw.disp_pos)
      DISP_LAMP:
      begin
        dlamp = 1'b1;
        dsrc = '1;
        ddp = '1;
      end
      DISP_STATUS:
        dsrc = {1'b0, status_word[31:24], 1'b0, status_word[23:16],
          1'b0, status_word[15:8], 1'b0, status_word[7:0]};
      DISP_ACCUM:
      begin
        dsrc = {1'b0, accum_word[31:24], 1'b0, accum_word[23:16],
          1'b0, accum_word[15:8], 1'b0, accum_word[7:0]};
        ddp = {2'b00, ~^accum_word[31:24], 2'b00, ~^accum_word[23:16],
          2'b00, ~^accum_word[15:8], 2'b00, ~^accum_word[7:0]};
      end
      DISP_HOST:
      begin
        dsrc = {host_addr, 6'h00, 1'b0, st_ff.mem[st_ff.mar],
          1'b0, st_ff.mar};
        dblank = BLANK_HOST;
      end
      DISP_KEYBD:
      begin
        // The interim register is shown live, so digits appear as typed.
        dsrc = {st_ff.interim, 9'h000, 1'b0, st_ff.mem[st_ff.mar],
          1'b0, st_ff.mar};
        dblank = kbd_mode ? BLANK_KEYBD :
          (BLANK_KEYBD | BLANK_KEY_DIGITS);
      end
      default:
        dblank = '1;
    endcase
  end

  // Each readout takes its own digit, blank and point.
  genvar k;
  generate
    for (k = 0; k < NUM_READOUTS; k++)
    begin : g_readout
      assign disp_next[k] = '{lamp_test: dlamp,
        blank: dblank[NUM_READOUTS-1-k],
        dp: ddp[NUM_READOUTS-1-k],
        value: dsrc[35-3*k -: 3]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.rdata = '0;
    nxt_st.disp = disp_next;

    // Two-stage synchroniser then a stability counter per button. A press
    // must hold for the whole window, so bounce never makes a second pulse.
    for (int i = 0; i < NUM_BTN; i++)
    begin
      nxt_st.sync1[i] = buttons[i];
      nxt_st.sync2[i] = st_ff.sync1[i];
      nxt_st.press[i] = 1'b0;
      if (st_ff.sync2[i] == st_ff.stable[i])
      begin
        nxt_st.dbnc_cnt[i] = '0;
      end
      else if (st_ff.dbnc_cnt[i] >= DBNC_LAST)
      begin
        nxt_st.dbnc_cnt[i] = '0;
        nxt_st.stable[i] = st_ff.sync2[i];
        nxt_st.press[i] = st_ff.sync2[i];
      end
      else
      begin
        nxt_st.dbnc_cnt[i] = st_ff.dbnc_cnt[i] + 1'b1;
      end
    end

    // Keyboard entry; keys do nothing outside load keyboard mode.
    if (kbd_mode)
    begin
      for (int d = 0; d < NUM_DIGIT_KEYS; d++)
      begin
        if (st_ff.press[d])
        begin
          nxt_st.interim = {st_ff.interim[5:0], 3'(d)};
        end
      end
      if (st_ff.press[BTN_CLEAR])
      begin
        nxt_st.interim = '0;
      end
      else if (st_ff.press[BTN_ADDR])
      begin
        nxt_st.mar = st_ff.interim[7:0];
      end
      else if (st_ff.press[BTN_DATA])
      begin
        // Interim is left alone so the next press repeats the byte.
        nxt_st.mem[st_ff.mar] = st_ff.interim[7:0];
        nxt_st.mar = st_ff.mar + 8'h01;
      end
    end

    // Tape reader entry; a parity error stops the reader.
    if (reader_mode && tape_valid && !st_ff.tape_stop)
    begin
      nxt_st.tape_reg = tape_byte;
      if (tape_parity_bad)
      begin
        nxt_st.tape_perr = 1'b1;
        nxt_st.tape_stop = 1'b1;
      end
      else
      begin
        nxt_st.mem[st_ff.mar] = tape_byte;
        nxt_st.mar = st_ff.mar + 8'h01;
      end
    end

    // Run and halt. Halt is held pending until the instruction ends.
    if (st_ff.run_halt_flag && st_ff.halt_pend && instr_done)
    begin
      nxt_st.run_halt_flag = 1'b0;
      nxt_st.halt_pend = 1'b0;
    end
    if (run_cmd && !panel_sw.load)
    begin
      nxt_st.run_halt_flag = 1'b1;
      nxt_st.halt_pend = 1'b0;
    end
    else if (halt_cmd && st_ff.run_halt_flag)
    begin
      nxt_st.halt_pend = 1'b1;
    end

    // Error flags: an event in the clearing cycle still sets the flag.
    nxt_st.status_err = st_ff.status_err | err_evt;
    if (reg_wr && (reg_addr == REG_STATUS))
    begin
      nxt_st.status_err = (st_ff.status_err &
        ~reg_wdata[STAT_ERR_LSB +: 4]) | err_evt;
    end

    // Software control of clock modes and transfer flags, host mode only.
    if (reg_wr && (reg_addr == REG_CTRL) && host_en)
    begin
      nxt_st.prog_one_shot = reg_wdata[CTRL_ONE_SHOT];
      nxt_st.prog_byte_step = reg_wdata[CTRL_BYTE_STEP];
      nxt_st.flags = reg_wdata[CTRL_FLAGS_LSB +: 4];
    end

    // Timing gate. The divider makes the 10 MHz rate from the system clock.
    nxt_st.div = tick10 ? 4'h0 : st_ff.div + 4'h1;
    unique case (st_ff.gate)
      GATE_FREE:
      begin
        if (one_shot_eff || byte_eff)
        begin
          nxt_st.gate = GATE_IDLE;
        end
        else
        begin
          nxt_st.tick = tick10;
        end
      end
      GATE_IDLE:
      begin
        if (!(one_shot_eff || byte_eff))
        begin
          nxt_st.gate = GATE_FREE;
        end
        else if (st_ff.press[BTN_ADVANCE])
        begin
          // One-shot wins over byte step when both are selected.
          nxt_st.byte_sel = one_shot_eff ? SINGLE_PULSE :
            BURST_PULSES;
          nxt_st.gate = GATE_BURST;
        end
      end
      GATE_BURST:
      begin
        if (tick10)
        begin
          nxt_st.tick = 1'b1;
          nxt_st.byte_sel = st_ff.byte_sel - 4'h1;
          if (st_ff.byte_sel == SINGLE_PULSE)
          begin
            nxt_st.gate = GATE_IDLE;
          end
        end
      end
    endcase

    // Register read; data stand in the following cycle only.
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:
          nxt_st.rdata = {24'h000000, st_ff.flags, 2'b00,
            st_ff.prog_byte_step, st_ff.prog_one_shot};
        REG_STATUS:
          nxt_st.rdata = {16'h0000, st_ff.status_err, 1'b0, byte_eff,
            one_shot_eff, st_ff.tape_perr, st_ff.tape_stop,
            panel_sw.test_panel, panel_sw.keyboard_src, panel_sw.load,
            st_ff.gate == GATE_BURST, 1'b0, st_ff.halt_pend,
            st_ff.run_halt_flag};
        REG_KEYPAD:
          nxt_st.rdata = {st_ff.mem[st_ff.mar], st_ff.mar, 7'h00,
            st_ff.interim};
        REG_TAPE:
          nxt_st.rdata = {24'h000000, st_ff.tape_reg};
        default:
          nxt_st.rdata = '0;
      endcase
    end

    // Panel reset button puts the documented flags to their start values.
    if (st_ff.press[BTN_RESET])
    begin
      nxt_st.interim = '0;
      nxt_st.tape_reg = '0;
      nxt_st.run_halt_flag = 1'b0;
      nxt_st.halt_pend = 1'b0;
      nxt_st.status_err = '0;
      nxt_st.byte_sel = '0;
      nxt_st.gate = GATE_FREE;
      nxt_st.tape_stop = 1'b0;
      nxt_st.tape_perr = 1'b0;
      nxt_st.flags = FLAGS_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; the clock enable freezes everything, but reset acts without it.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= ST_RESET;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken from the state register.
  assign reg_rdata = st_ff.rdata;
  assign readouts = st_ff.disp;
  assign timing_tick = st_ff.tick;
  assign run_lamp = st_ff.run_halt_flag;
  assign mode_flags = st_ff.flags;
  assign tape_stop = st_ff.tape_stop;
  assign tape_parity_err = st_ff.tape_perr;
  assign status_err = st_ff.status_err;

endmodule // front_panel_control
`default_nettype wire

// *** bench/front_panel_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module front_panel_properties
  import front_panel_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Watched ports.
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire panel_sw_t panel_sw,
  input wire logic instr_done,
  input wire logic [3:0] err_evt,
  input wire readout_t [NUM_READOUTS-1:0] readouts,
  input wire logic timing_tick,
  input wire logic run_lamp,
  input wire flags_t mode_flags,
  input wire logic [3:0] status_err
);
  logic sw_n;
  logic no_key;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Shorthands for the switch states that the properties lean on.
  assign sw_n = panel_sw.clk_sw == CLK_SW_NORMAL;
  assign no_key = !(panel_sw.load && panel_sw.keyboard_src);
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_flags:
    assert property ($rose(resetn) |-> mode_flags == 4'hc && !run_lamp)
    else $error("flags or run state wrong after reset");
  chk_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data present without a read");
  chk_err_sticky:
    assert property (|err_evt |=>
      (status_err & $past(err_evt)) == $past(err_evt))
    else $error("error event not latched");
  chk_halt_wait:
    assert property (run_lamp && !instr_done |=> run_lamp)
    else $error("run stopped before the instruction finished");
  chk_lamp_all:
    assert property (panel_sw.disp_pos == DISP_LAMP |=>
      readouts == {12{6'h2f}})
    else $error("lamp test not lighting every segment");
  chk_host_blank:
    assert property (panel_sw.disp_pos == DISP_HOST |=>
      readouts[4].blank && readouts[5].blank)
    else $error("host view readouts five and six not blank");
  chk_key_blank:
    assert property (panel_sw.disp_pos == DISP_KEYBD && no_key |=>
      readouts[0].blank && readouts[1].blank && readouts[2].blank)
    else $error("keyboard digits shown outside load keyboard");
  chk_tick_gap:
    assert property (timing_tick |=> !timing_tick [*8])
    else $error("timing pulses too close");
  chk_tick_free:
    assert property (sw_n && timing_tick ##1 sw_n [*8] ##1 sw_n |=>
      timing_tick)
    else $error("free running pulse period wrong");
  // Main scenarios reached.
  cover property (run_lamp && instr_done);
  cover property (panel_sw.disp_pos == DISP_KEYBD && !no_key);
  cover property (timing_tick && panel_sw.clk_sw == CLK_SW_ONE_SHOT);
endmodule // front_panel_properties
`default_nettype wire

// *** bench/host_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_core_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Bench commands and unit state.
  input wire logic go_run,
  input wire logic go_halt,
  input wire logic [4:0] gap,
  input wire logic run_lamp,
  // Host commands and core completion.
  output logic host_run_req,
  output logic host_halt_req,
  output logic instr_done
);
  logic [4:0] cnt_ff;
  // The core ends an instruction every gap plus one cycles while running, so a
  // large gap keeps a halt pending for a long time.
  always_ff @(posedge clk)
  begin
    host_run_req <= resetn && go_run;
    host_halt_req <= resetn && go_halt;
    cnt_ff <= (!resetn || !run_lamp || cnt_ff >= gap) ? 5'h0 : cnt_ff + 5'h1;
    instr_done <= resetn && run_lamp && cnt_ff == gap;
  end
endmodule // host_core_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import front_panel_pkg::*;
  localparam int DBN = 4;
  logic clk, resetn, reg_wr, reg_rd, tape_valid, tape_parity_bad;
  logic go_run, go_halt, host_run_req, host_halt_req, instr_done;
  logic timing_tick, run_lamp, tape_stop, tape_parity_err;
  logic [7:0] reg_addr, tape_byte, a, d;
  logic [31:0] reg_wdata, reg_rdata, status_word, accum_word, rd_val;
  logic [11:0] host_addr;
  logic [3:0] err_evt, status_err;
  logic [4:0] gap;
  logic [NUM_BTN-1:0] buttons;
  panel_sw_t panel_sw;
  flags_t mode_flags;
  readout_t [NUM_READOUTS-1:0] readouts;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_tick = 0;
  int t0;
  logic [31:0] seed = 32'd71;
  // Clock enable held high: freezing is outside these tests.
  front_panel_control #(.DEBOUNCE_LEN(DBN)) dut (.clk, .resetn, .ce(1'b1),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .panel_sw, .buttons,
    .host_run_req, .host_halt_req, .instr_done, .tape_valid, .tape_byte,
    .tape_parity_bad, .err_evt, .status_word, .accum_word, .host_addr,
    .readouts, .timing_tick, .run_lamp, .mode_flags, .tape_stop,
    .tape_parity_err, .status_err);
  host_core_model partner (.clk, .resetn, .go_run, .go_halt, .gap, .run_lamp,
    .host_run_req, .host_halt_req, .instr_done);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and pulse counter.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (timing_tick === 1'b1)
      n_tick <= n_tick + 1;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Octal digit i of a word shown as four three-digit bytes.
  function automatic logic [2:0] oct(logic [31:0] w, int i);
    logic [7:0] b;
    b = w[31-8*(i/3) -: 8];
    return 3'({1'b0, b} >> (3*(2-i%3)));
  endfunction
  function automatic logic [3:0] expect_ro(int p, int i);
    logic [7:0] b;
    b = accum_word[31-8*(i/3) -: 8];
    if (p == 1)
      return {1'b0, oct(status_word, i)};
    if (p == 2)
      return {(i % 3 == 2) && ~^b, oct(accum_word, i)};
    return {1'b0, host_addr[11-3*i -: 3]};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // A press is held and released long enough to pass the debouncer.
  task automatic press(int k);
    @(posedge clk);
    buttons[k] <= 1'b1;
    tick(DBN + 8);
    buttons[k] <= 1'b0;
    tick(DBN + 8);
  endtask
  task automatic enter(logic [7:0] v);
    for (int i = 0; i < 3; i++)
      press(int'(oct({v, 24'h0}, i)));
  endtask
  task automatic host(logic h);
    @(posedge clk);
    go_run <= !h;
    go_halt <= h;
    @(posedge clk);
    {go_run, go_halt} <= 2'b00;
  endtask
  task automatic wait_lamp(logic v);
    for (int k = 0; k < 60 && run_lamp !== v; k++)
      @(negedge clk);
    check("run_lamp", 32'(run_lamp), 32'(v));
  endtask
  task automatic reset_and_check();
    resetn <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(1);
    #1 check("mode_flags", 32'(mode_flags), 32'hc);
    check("cleared", 32'({run_lamp, tape_stop, tape_parity_err, status_err}),
      32'h0);
  endtask
  task automatic count_ticks(int exp);
    tick(30);
    t0 = n_tick;
    tick(100);
    check("ticks", n_tick - t0, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog for a hung sequence.
  initial
  begin
    tick(20000);
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence.
  initial
  begin
    {resetn, reg_wr, reg_rd, tape_valid, tape_parity_bad, go_run} = '0;
    {go_halt, reg_addr, tape_byte, reg_wdata, err_evt, buttons} = '0;
    panel_sw = '0;
    gap = 5'd12;
    status_word = xs();
    accum_word = xs();
    host_addr = 12'(xs());
    reset_and_check();
    wr(REG_CTRL, 32'h30);
    panel_sw.test_panel <= 1'b1;
    wr(REG_CTRL, 32'hc0);
    tick(1);
    check("mode_flags", 32'(mode_flags), 32'h3);
    err_evt <= 4'h5;
    wr(REG_STATUS, 32'h5000);
    err_evt <= 4'h0;
    tick(1);
    check("status_err", 32'(status_err), 32'h5);
    wr(REG_STATUS, 32'h5000);
    rd(8'h1c);
    check("unmapped", rd_val, 32'h0);
    check("status_err", 32'(status_err), 32'h0);
    $display("test registers done");
    panel_sw.load <= 1'b1;
    panel_sw.keyboard_src <= 1'b1;
    panel_sw.disp_pos <= DISP_KEYBD;
    for (int n = 0; n < 4; n++)
    begin
      a = (n == 0) ? 8'hff : 8'(xs());
      d = 8'(xs());
      enter(a);
      press(BTN_ADDR);
      enter(d);
      check("digit", 32'({readouts[2].blank, readouts[2].value}),
        32'(d[2:0]));
      press(BTN_DATA);
      press(BTN_DATA);
      rd(REG_KEYPAD);
      check("address", 32'(rd_val[23:16]),
        32'(8'(a + 8'h2)));
      check("interim", 32'(rd_val[8:0]), 32'(d));
      enter(a + 8'h1);
      press(BTN_ADDR);
      rd(REG_KEYPAD);
      check("memory", 32'(rd_val[31:24]), 32'(d));
      check("interim", 32'(rd_val[8:0]), 32'(8'(a + 8'h1)));
    end
    press(BTN_CLEAR);
    rd(REG_KEYPAD);
    check("interim", 32'(rd_val[8:0]), 32'h0);
    panel_sw.load <= 1'b0;
    tick(2);
    check("key_blank", 32'(readouts[0].blank), 32'h1);
    $display("test keyboard done");
    for (int p = 1; p < 4; p++)
    begin
      panel_sw.disp_pos <= disp_pos_t'(p);
      tick(3);
      for (int i = 0; i < (p == 3 ? 4 : 12); i++)
        check("readout", 32'({readouts[i].dp, readouts[i].value}),
          32'(expect_ro(p, i)));
    end
    $display("test display done");
    panel_sw.test_panel <= 1'b0;
    host(1'b0);
    wait_lamp(1'b1);
    host(1'b1);
    wait_lamp(1'b0);
    wr(REG_CMD, 32'h1);
    wait_lamp(1'b1);
    wr(REG_CMD, 32'h2);
    wait_lamp(1'b0);
    panel_sw.test_panel <= 1'b1;
    host(1'b0);
    wr(REG_CMD, 32'h1);
    tick(6);
    check("run_lamp", 32'(run_lamp), 32'h0);
    press(BTN_RUN);
    wait_lamp(1'b1);
    host(1'b1);
    tick(30);
    check("run_lamp", 32'(run_lamp), 32'h1);
    press(BTN_HALT);
    wait_lamp(1'b0);
    $display("test run done");
    panel_sw.test_panel <= 1'b0;
    wr(REG_CTRL, 32'hc1);
    panel_sw.clk_sw <= CLK_SW_NORMAL;
    count_ticks(10);
    panel_sw.clk_sw <= CLK_SW_CENTER;
    count_ticks(0);
    panel_sw.clk_sw <= CLK_SW_ONE_SHOT;
    tick(30);
    t0 = n_tick;
    press(BTN_ADVANCE);
    tick(30);
    check("one_shot", n_tick - t0, 1);
    wr(REG_CTRL, 32'h30);
    panel_sw.clk_sw <= CLK_SW_CENTER;
    panel_sw.byte_sw <= SW3_ON;
    tick(30);
    t0 = n_tick;
    press(BTN_ADVANCE);
    tick(100);
    check("burst", n_tick - t0, 8);
    $display("test clock done");
    panel_sw.load <= 1'b1;
    panel_sw.keyboard_src <= 1'b0;
    tape_byte <= 8'(xs());
    tape_valid <= 1'b1;
    tape_parity_bad <= 1'b1;
    tick(1);
    tape_valid <= 1'b0;
    rd(REG_TAPE);
    check("tape_reg", 32'(rd_val[7:0]), 32'(tape_byte));
    check("tape_err", 32'({tape_stop, tape_parity_err}), 32'h3);
    press(BTN_RESET);
    check("soft_reset", 32'({tape_stop, tape_parity_err, mode_flags}),
      32'hc);
    wr(REG_CTRL, 32'h30);
    err_evt <= 4'h9;
    tick(1);
    err_evt <= 4'h0;
    reset_and_check();
    $display("test tape done");
    tally_and_finish();
  end
endmodule // testbench
bind front_panel_control front_panel_properties chk (.clk(clk),
  .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .panel_sw(panel_sw), .instr_done(instr_done), .err_evt(err_evt),
  .readouts(readouts), .timing_tick(timing_tick), .run_lamp(run_lamp),
  .mode_flags(mode_flags), .status_err(status_err));
`default_nettype wire
